// *** src/debc_pkg.sv ***
// shared constants and types for the external bus control block
package debc_pkg;
  localparam logic [15:0] DEBC_RESET_VECTOR = 16'hff80;
  localparam logic [15:0] DEBC_ROM_BASE     = 16'hc000; // top 16k words of program space
  localparam logic [2:0]  DEBC_WS_MIN_READY = 3'h2;     // ready is watched from two waits up
  localparam logic [2:0]  DEBC_WS_NONE      = 3'h0;
  localparam int          DEBC_WS_W         = 3;
  localparam int          DEBC_ADDR_W       = 16;

  typedef enum logic [1:0] {
    DEBC_SP_DATA,
    DEBC_SP_PROG,
    DEBC_SP_IO
  } debc_space_t;

  typedef enum logic [1:0] {
    DEBC_FLAG_NOP,
    DEBC_FLAG_SET,
    DEBC_FLAG_CLR,
    DEBC_FLAG_LOAD
  } debc_flag_op_t;
endpackage : debc_pkg

// *** src/debc_pin_if.sv ***
// pin-level value and enable group passed from the sequencer to the pad stage
`timescale 1ns/1ps
interface debc_pin_if;
  logic ds_n;
  logic ps_n;
  logic is_n;
  logic memory_strobe_n_n;
  logic io_strobe_n_n;
  logic rw;
  logic grant_n;
  logic msc_n;
  logic iaq_n;
  logic flag;
  logic hold_float;
  logic off_n;
  modport src (output ds_n, ps_n, is_n, memory_strobe_n_n, io_strobe_n_n, rw, grant_n, msc_n, iaq_n,
               flag, hold_float, off_n);
  modport dst (input ds_n, ps_n, is_n, memory_strobe_n_n, io_strobe_n_n, rw, grant_n, msc_n, iaq_n,
               flag, hold_float, off_n);
endinterface : debc_pin_if

// *** src/debc_pad_stage.sv ***
// registered pin drive values and output enables for the control pins
`timescale 1ns/1ps
module debc_pad_stage (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic clk_en_i,
  debc_pin_if.dst   pin,
  output logic [9:0] val_o,
  output logic [9:0] oe_o
);
  // bit order: ds ps is memory_strobe_n io_strobe_n rw grant msc iaq flag
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      val_o <= 10'h3ff;
      oe_o  <= 10'h000;
    end else if (clk_en_i) begin
      val_o <= {pin.ds_n, pin.ps_n, pin.is_n, pin.memory_strobe_n_n, pin.io_strobe_n_n, pin.rw,
                pin.grant_n, pin.msc_n, pin.iaq_n, pin.flag};
      if (!pin.off_n) begin
        oe_o <= 10'h000;
      end else if (pin.hold_float) begin
        oe_o <= 10'h00f;
      end else begin
        oe_o <= 10'h3ff;
      end
    end
  end
endmodule : debc_pad_stage

// *** src/debc_bus_ctrl.sv ***
// external bus control: selects, strobes, waits, hold handover and pin functions
// How it works
// - reset halts; first fetch at reset vector
// - rom select low maps rom at top
// - strap caught at reset; mode bit overrides
// - branch input low; sampled decode or read
// - flag latched: set, clear, load st1
// - one space select low during access
// - memory strobe low for data/program access
// - io strobe low for io access
// - direction high, low only on writes
// - ready low adds cycle, two+ waits
// - ready sampled after software waits
// - hold request floats lines once granted
// - grant low only while floated
// - hold floats selects, strobes, direction
// - msc low from first wait until last wait starts
// - msc looped to ready adds no wait
// - fetch indicator low with instruction address
// - output-off low tri-states control outputs
`timescale 1ns/1ps
module debc_bus_ctrl
  import debc_pkg::*;
(
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  input  wire logic                   clk_en_i,
  input  wire logic                   chip_reset_n_i,
  input  wire logic                   rom_map_select_i,
  input  wire logic                   processor_mode_reg_mode_wr_i,
  input  wire logic                   processor_mode_reg_mode_i,
  input  wire logic                   req_valid_i,
  input  wire debc_space_t            req_space_i,
  input  wire logic                   req_write_i,
  input  wire logic                   req_fetch_i,
  input  wire logic [DEBC_ADDR_W-1:0] req_addr_i,
  input  wire logic [DEBC_WS_W-1:0]   wait_states_i,
  input  wire logic                   ready_i,
  input  wire logic                   hold_req_n_i,
  input  wire logic                   output_off_n_i,
  input  wire logic                   branch_condition_in_i,
  input  wire logic                   cond_decode_i,
  input  wire logic                   cond_read_i,
  input  wire logic                   conditional_execute_instr_i,
  input  wire debc_flag_op_t          flag_op_i,
  input  wire logic                   flag_load_val_i,
  output logic                        req_ready_o,
  output logic                        access_done_o,
  output logic                        rom_hit_o,
  output logic                        rom_mapped_o,
  output logic [DEBC_ADDR_W-1:0]      fetch_addr_o,
  output logic                        cond_true_o,
  output logic                        running_o,
  output logic [9:0]                  pin_val_o,
  output logic [9:0]                  pin_oe_o
);
  typedef enum logic [2:0] {
    DEBC_ST_RESET,
    DEBC_ST_IDLE,
    DEBC_ST_WAIT,
    DEBC_ST_READY,
    DEBC_ST_LAST,
    DEBC_ST_HOLD
  } debc_state_t;

  debc_state_t                state_q;
  debc_space_t                space_q;
  logic                       write_q;
  logic                       fetch_q;
  logic [DEBC_WS_W-1:0]       ws_q;
  logic [DEBC_WS_W-1:0]       ws_cnt_q;
  logic                       rom_mode_q;
  logic                       rst_seen_q;
  logic                       flag_q;
  logic                       msc_n_q;
  debc_pin_if                 pin ();

  function automatic logic is_rom_addr(input logic [DEBC_ADDR_W-1:0] a);
    is_rom_addr = (a >= DEBC_ROM_BASE);
  endfunction : is_rom_addr

  wire logic in_access = (state_q == DEBC_ST_WAIT) || (state_q == DEBC_ST_READY) ||
                         (state_q == DEBC_ST_LAST);
  wire logic ready_check = (ws_q >= DEBC_WS_MIN_READY);

  // bus sequencer
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q       <= DEBC_ST_RESET;
      space_q       <= DEBC_SP_DATA;
      write_q       <= 1'b0;
      fetch_q       <= 1'b0;
      ws_q          <= DEBC_WS_NONE;
      ws_cnt_q      <= DEBC_WS_NONE;
      access_done_o <= 1'b0;
    end else if (clk_en_i) begin
      access_done_o <= 1'b0;
      if (!chip_reset_n_i) begin
        state_q <= DEBC_ST_RESET;
      end else begin
        unique case (state_q)
          DEBC_ST_RESET: state_q <= DEBC_ST_IDLE;
          DEBC_ST_IDLE: begin
            if (!hold_req_n_i) begin
              state_q <= DEBC_ST_HOLD;
            end else if (req_valid_i) begin
              space_q  <= req_space_i;
              write_q  <= req_write_i;
              fetch_q  <= req_fetch_i;
              ws_q     <= wait_states_i;
              ws_cnt_q <= wait_states_i;
              state_q  <= (wait_states_i == DEBC_WS_NONE) ? DEBC_ST_LAST : DEBC_ST_WAIT;
            end
          end
          DEBC_ST_WAIT: begin
            // ready is ignored until the software count runs out
            if (ws_cnt_q == 3'h1) begin
              state_q <= ready_check ? DEBC_ST_READY : DEBC_ST_LAST;
            end
            ws_cnt_q <= ws_cnt_q - 3'h1;
          end
          DEBC_ST_READY: begin
            // msc is already high here, so a looped msc adds no extra wait
            if (ready_i) begin
              state_q <= DEBC_ST_LAST;
            end
          end
          DEBC_ST_LAST: begin
            access_done_o <= 1'b1;
            state_q       <= DEBC_ST_IDLE;
          end
          DEBC_ST_HOLD: begin
            if (hold_req_n_i) begin
              state_q <= DEBC_ST_IDLE;
            end
          end
          // two of the eight codes are unused; fall back to a clean restart
          default: state_q <= DEBC_ST_RESET;
        endcase
      end
    end
  end

  // msc low from first wait until start of last wait
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      msc_n_q <= 1'b1;
    end else if (clk_en_i) begin
      if (state_q == DEBC_ST_IDLE && req_valid_i && hold_req_n_i && chip_reset_n_i &&
          wait_states_i >= DEBC_WS_MIN_READY) begin
        msc_n_q <= 1'b0;
      end else if (state_q == DEBC_ST_WAIT && ws_cnt_q == 3'h2) begin
        msc_n_q <= 1'b1;
      end else if (!in_access || !chip_reset_n_i) begin
        // a chip reset cutting an access must not leave msc low without a strobe
        msc_n_q <= 1'b1;
      end
    end
  end

  // rom mapping strap caught while reset is held, mode bit may override
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rom_mode_q <= 1'b0;
      rst_seen_q <= 1'b0;
    end else if (clk_en_i) begin
      rst_seen_q <= !chip_reset_n_i;
      if (!chip_reset_n_i) begin
        rom_mode_q <= !rom_map_select_i;
      end else if (processor_mode_reg_mode_wr_i) begin
        rom_mode_q <= !processor_mode_reg_mode_i;
      end
    end
  end

  // software flag
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_q <= 1'b1;
    end else if (clk_en_i) begin
      if (!chip_reset_n_i) begin
        flag_q <= 1'b1;
      end else begin
        unique case (flag_op_i)
          DEBC_FLAG_NOP:  flag_q <= flag_q;
          DEBC_FLAG_SET:  flag_q <= 1'b1;
          DEBC_FLAG_CLR:  flag_q <= 1'b0;
          DEBC_FLAG_LOAD: flag_q <= flag_load_val_i;
        endcase
      end
    end
  end

  // branch condition, sampled in the pipeline phase the instruction uses
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cond_true_o <= 1'b0;
    end else if (clk_en_i) begin
      if (conditional_execute_instr_i ? cond_decode_i : cond_read_i) begin
        cond_true_o <= !branch_condition_in_i;
      end
    end
  end

  // status and reset vector outputs
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_ready_o  <= 1'b0;
      rom_hit_o    <= 1'b0;
      rom_mapped_o <= 1'b0;
      fetch_addr_o <= DEBC_RESET_VECTOR;
      running_o    <= 1'b0;
    end else if (clk_en_i) begin
      req_ready_o  <= (state_q == DEBC_ST_IDLE) && hold_req_n_i && chip_reset_n_i;
      rom_mapped_o <= rom_mode_q;
      rom_hit_o    <= rom_mode_q && req_valid_i && req_space_i == DEBC_SP_PROG &&
                      is_rom_addr(req_addr_i);
      running_o    <= chip_reset_n_i && !rst_seen_q;
      if (!chip_reset_n_i) begin
        fetch_addr_o <= DEBC_RESET_VECTOR;
      end
    end
  end

  // pin values; only the current space goes low
  always_comb begin
    pin.ds_n       = !(in_access && space_q == DEBC_SP_DATA);
    pin.ps_n       = !(in_access && space_q == DEBC_SP_PROG);
    pin.is_n       = !(in_access && space_q == DEBC_SP_IO);
    pin.memory_strobe_n_n    = !(in_access && space_q != DEBC_SP_IO);
    pin.io_strobe_n_n   = !(in_access && space_q == DEBC_SP_IO);
    pin.rw         = !(in_access && write_q);
    pin.grant_n    = !(state_q == DEBC_ST_HOLD);
    pin.msc_n      = msc_n_q;
    pin.iaq_n      = !(in_access && fetch_q && space_q == DEBC_SP_PROG);
    pin.flag       = flag_q;
    pin.hold_float = (state_q == DEBC_ST_HOLD);
    pin.off_n      = output_off_n_i;
  end

  debc_pad_stage u_pad (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .pin       (pin.dst),
    .val_o     (pin_val_o),
    .oe_o      (pin_oe_o)
  );
endmodule : debc_bus_ctrl

// *** bench/debc_bus_ctrl_sva.sv ***
// assertions on the bus control pins and the zero-wait done timing
`timescale 1ns/1ps
module debc_bus_ctrl_sva
  import debc_pkg::*;
(
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 chip_reset_n_i,
  input wire logic                 output_off_n_i,
  input wire logic                 req_valid_i,
  input wire logic                 hold_req_n_i,
  input wire logic [DEBC_WS_W-1:0] wait_states_i,
  input wire logic                 req_ready_o,
  input wire logic                 access_done_o,
  input wire logic [9:0]           pin_val_o,
  input wire logic [9:0]           pin_oe_o
);
  wire [9:0] v = pin_val_o;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_one_select: assert property ($onehot0(~v[9:7])) else $error("select clash");
  a_mem_strobe: assert property (!v[6] |-> v[5] && v[7] && !(v[9] && v[8]))
    else $error("memory_strobe_n off space");
  a_io_strobe: assert property (!v[5] |-> !v[7] && v[6]) else $error("io_strobe_n off space");
  a_write_dir: assert property (!v[4] |-> !(v[6] && v[5])) else $error("rw low idle");
  a_wait_flag: assert property (!v[2] |-> !(v[6] && v[5])) else $error("msc idle");
  a_grant_float: assert property (!v[3] && pin_oe_o[3] |-> pin_oe_o[9:4] == 6'h00)
    else $error("grant while driving");
  a_off_float: assert property ((!output_off_n_i)[*3] |-> pin_oe_o == 10'h000)
    else $error("off not floated");
  a_flag_reset: assert property ((!chip_reset_n_i)[*3] |-> v[0]) else $error("flag low");
  a_zero_wait: assert property (req_valid_i && req_ready_o && hold_req_n_i && chip_reset_n_i
    && wait_states_i == 3'h0 |=> !access_done_o ##1 access_done_o) else $error("done late");
endmodule : debc_bus_ctrl_sva

bind debc_bus_ctrl debc_bus_ctrl_sva u_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .chip_reset_n_i(chip_reset_n_i), .output_off_n_i(output_off_n_i), .req_valid_i(req_valid_i),
  .hold_req_n_i(hold_req_n_i), .wait_states_i(wait_states_i), .req_ready_o(req_ready_o),
  .access_done_o(access_done_o), .pin_val_o(pin_val_o), .pin_oe_o(pin_oe_o));

// *** bench/debc_ext_dev.sv ***
// far-side device model: stalls ready for a set count after each access start
`timescale 1ns/1ps
module debc_ext_dev (
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       start_i,
  input  wire logic [4:0] low_i,
  output logic            ready_o
);
  logic [4:0] cnt_q;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 5'h00;
    end else if (start_i) begin
      cnt_q <= low_i;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
  // low while stalling, one cycle per count, so a waiting master sees it each cycle
  assign ready_o = (cnt_q == 5'h00);
endmodule : debc_ext_dev

// *** bench/dsp_external_bus_control_bench.sv ***
// self-checking bench for the external bus control block
`timescale 1ns/1ps
module dsp_external_bus_control_bench;
  import debc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, crn = 1'b0, msel = 1'b1, mwr = 1'b0, mbit = 1'b0;
  logic vld = 1'b0, wr = 1'b0, fch = 1'b0, hold_n = 1'b1, off_n = 1'b1, st = 1'b0;
  logic branch_condition_in = 1'b1, dec = 1'b0, rd = 1'b0, xc = 1'b0, fval = 1'b0, rdy_in, rdy, done;
  logic ctrue, mapped, run, hit, en = 1'b1;
  logic [2:0] ws = 3'h0;
  logic [4:0] low = 5'h00;
  logic [15:0] addr = 16'h0000, fa;
  logic [9:0] pv, poe;
  logic [31:0] lf = 32'h948b;
  debc_space_t sp = DEBC_SP_DATA;
  debc_flag_op_t fop = DEBC_FLAG_NOP;
  int n_errors = 0, total_checks = 0, cyc = 0, lo_q[$], hi_q[$];
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  debc_bus_ctrl u_dut (.mclk_i(clk), .sys_rst_i(rst), .clk_en_i(en), .chip_reset_n_i(crn),
    .rom_map_select_i(msel), .processor_mode_reg_mode_wr_i(mwr), .processor_mode_reg_mode_i(mbit), .req_valid_i(vld),
    .req_space_i(sp), .req_write_i(wr), .req_fetch_i(fch), .req_addr_i(addr),
    .wait_states_i(ws), .ready_i(rdy_in), .hold_req_n_i(hold_n), .output_off_n_i(off_n),
    .branch_condition_in_i(branch_condition_in), .cond_decode_i(dec), .cond_read_i(rd),
    .conditional_execute_instr_i(xc), .flag_op_i(fop), .flag_load_val_i(fval),
    .req_ready_o(rdy), .access_done_o(done), .rom_hit_o(hit), .rom_mapped_o(mapped),
    .fetch_addr_o(fa), .cond_true_o(ctrue), .running_o(run), .pin_val_o(pv), .pin_oe_o(poe));
  debc_ext_dev u_dev (.mclk_i(clk), .sys_rst_i(rst), .start_i(st), .low_i(low), .ready_o(rdy_in));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic tmo();
    n_errors++;
    complete_run();
  endtask : tmo
  task automatic cy(input int n);
    repeat (n) @(negedge clk);
  endtask : cy
  // the done pulse is matched against a window of edges counted from the take edge
  // both notes are taken off first so the two queues never drift apart
  always @(negedge clk) begin : done_watch
    int lo, hi;
    if (done === 1'b1) begin
      if (lo_q.size() == 0) begin
        chk(16'h1, 16'h0);
      end else begin
        lo = lo_q.pop_front();
        hi = hi_q.pop_front();
        chk({15'h0, cyc >= lo && cyc <= hi}, 16'h1);
      end
    end
  end
  task automatic acc(input logic [2:0] n, input logic [4:0] l, input int lo, input int hi);
    int i;
    for (i = 0; i < 50 && rdy !== 1'b1; i++) cy(1);
    if (i == 50) tmo();
    vld = 1'b1;
    ws = n;
    low = l;
    st = 1'b1;
    lo_q.push_back(cyc + 1 + lo);
    hi_q.push_back(cyc + 1 + hi);
    cy(1);
    vld = 1'b0;
    st = 1'b0;
    chk(hit, {15'h0, sp == DEBC_SP_PROG && addr >= DEBC_ROM_BASE});
    // the pad register shows the first access cycle one edge later, for any wait count
    cy(1);
    chk({pv[9:4], pv[1]}, {~(3'b100 >> sp), sp == DEBC_SP_IO,
      sp != DEBC_SP_IO, !wr, !fch});
    for (i = 0; i < 60 && lo_q.size() != 0; i++) cy(1);
    if (i == 60) tmo();
    cy(2);
  endtask : acc
  initial begin
    int i, e;
    cy(10);
    rst = 1'b0;
    chk(fa, DEBC_RESET_VECTOR);
    // chip reset stays low past the bench reset so the strap is really caught
    cy(2);
    chk(run, 16'h0);
    crn = 1'b1;
    msel = 1'b0;
    cy(3);
    chk({mapped, pv[0], run}, 16'h3);
    for (int k = 0; k < 2; k++) begin
      mbit = k[0];
      mwr = 1'b1;
      cy(1);
      mwr = 1'b0;
      cy(2);
      chk(mapped, {15'h0, !k[0]});
    end
    crn = 1'b0;
    cy(3);
    chk(run, 16'h0);
    crn = 1'b1;
    cy(3);
    chk({mapped, run}, 16'h3);
    for (int k = 0; k < 4; k++) begin
      fop = (k == 0) ? DEBC_FLAG_CLR : (k == 1) ? DEBC_FLAG_SET : DEBC_FLAG_LOAD;
      fval = k[0];
      xc = k[1];
      branch_condition_in = k[0];
      dec = k[1];
      rd = !k[1];
      cy(1);
      fop = DEBC_FLAG_NOP;
      dec = 1'b0;
      rd = 1'b0;
      cy(3);
      chk({pv[0], ctrue}, {k[0], !k[0]});
    end
    // the conditional-execute case must ignore the read-phase strobe
    branch_condition_in = 1'b0;
    xc = 1'b1;
    rd = 1'b1;
    cy(1);
    rd = 1'b0;
    cy(2);
    chk(ctrue, 16'h0);
    for (int k = 0; k < 8; k++) begin
      lf = nxt(lf);
      sp = debc_space_t'(lf[1:0] % 2'h3);
      wr = lf[2];
      fch = lf[3] && sp == DEBC_SP_PROG;
      addr = lf[31:16];
      // below two waits there is no ready-sample cycle
      e = lf[5:4] + ((lf[5:4] > 2'h1) ? 2 : 1);
      acc({1'b0, lf[5:4]}, 5'h00, e, e);
    end
    sp = DEBC_SP_PROG;
    addr = 16'hff80;
    // one wait: ready ignored; four waits: stall hidden inside them; two waits: stall counts
    acc(3'h1, 5'h14, 2, 2);
    acc(3'h4, 5'h03, 6, 6);
    acc(3'h2, 5'h14, 21, 23);
    hold_n = 1'b0;
    for (i = 0; i < 20 && pv[3] !== 1'b0; i++) cy(1);
    if (i == 20) tmo();
    vld = 1'b1;
    cy(5);
    chk({poe[9:4], rdy}, 16'h0);
    vld = 1'b0;
    hold_n = 1'b1;
    cy(4);
    chk(pv[3], 16'h1);
    off_n = 1'b0;
    cy(3);
    chk(poe, 16'h0);
    off_n = 1'b1;
    cy(3);
    chk(poe[0], 16'h1);
    // a clear while the clock enable is low must be lost
    en = 1'b0;
    fop = DEBC_FLAG_CLR;
    cy(3);
    fop = DEBC_FLAG_NOP;
    en = 1'b1;
    cy(3);
    chk(pv[0], 16'h1);
    complete_run();
  end
endmodule : dsp_external_bus_control_bench
